/* File: hdl/pmd_button_track.sv */
/*
 * Button level and two-bit edge counters for the button-status register.
 * Assumes button_level is already synchronous to mclk.
 */
`timescale 1ns/1ns
module pmd_button_track (
    input  wire logic           mclk,
    input  wire logic           srst,
    input  wire logic           ce,
    input  wire logic           button_level,
    input  wire logic           clear,
    output pmd_pkg::pmd_button_t status
);

    wire       rose;
    wire       fell;
    wire [1:0] next_rise_count;
    wire [1:0] next_fall_count;

    assign rose = button_level & ~status.level;
    assign fell = ~button_level & status.level;
    // restart on write
    // an edge in the clearing cycle still counts once
    assign next_rise_count = (clear ? 2'h0 : status.rise_count) + {1'b0, rose};
    assign next_fall_count = (clear ? 2'h0 : status.fall_count) + {1'b0, fell};

    always_ff @(posedge mclk) begin
        if (srst) begin
            status <= '0;
        end else if (ce) begin
            status.level      <= button_level;
            status.rise_count <= next_rise_count;
            status.fall_count <= next_fall_count;
        end
    end

endmodule : pmd_button_track

/* File: hdl/pmd_pkg.sv */
/*
 * Shared constants, register map and carrier types of the power-mode
 * downshift block: register offsets, reset values, field positions,
 * downshift multipliers and frame timing.
 * Assumes a single 100 MHz clock and a synchronous active-high reset.
 */
// How it works
// - Bit 0 of the button-status register shows the button level as it is now.
// - Bits 7:6 of the button-status register count rising button edges, two bits wide.
// - Bits 5:4 of the button-status register count falling button edges, two bits wide.
// - Any write to the button-status register restarts both counters from zero, an edge in the write cycle still counting once, and stores nothing.
// - Run mode drops to rest one after the run field times 8 run frames; field resets to 0x04.
// - Run frame timing comes from mclk, giving a run frame every 8 ms.
// - Rest one takes one frame every (its period field plus one) times 10 ms.
// - Rest one drops to rest two after its field times 16 rest-one frames; reset 0x1f.
// - Rest two takes one frame every (its period field plus one) times 10 ms; reset 0x09.
// - Rest two drops to rest three after its field times 128 rest-two frames; reset 0x2f.
// - Rest three takes one frame every (its period field plus one) times 10 ms; reset 0x31.
// - Rest frame periods count ticks of the 100 Hz hibernate clock; downshift times count frames of their mode.
// - The lamp register sets the three-bit drive code, and its force bit keeps the lamp lit.
package pmd_pkg;

    // clock and timing
    localparam int MCLK_MHZ          = 100;
    localparam int SYS_CLK_MHZ       = 25;
    localparam int RUN_FRAME_MS      = 8;
    localparam int HIB_CLK_HZ        = 100;
    localparam int HIB_TICK_MS       = 1000 / HIB_CLK_HZ;
    localparam int RUN_FRAME_CYCLES  = RUN_FRAME_MS * 1000 * MCLK_MHZ;
    localparam int HIB_TICK_CYCLES   = HIB_TICK_MS * 1000 * MCLK_MHZ;
    localparam int TICK_CNT_W        = 20;

    // downshift multipliers
    localparam logic [7:0] RUN_SHIFT_MULT      = 8'h08;
    localparam logic [7:0] REST_ONE_SHIFT_MULT = 8'h10;
    localparam logic [7:0] REST_TWO_SHIFT_MULT = 8'h80;

    // register offsets
    localparam logic [7:0] ADDR_BUTTON_STATE_COUNTS     = 8'h12;
    localparam logic [7:0] ADDR_RUN_DOWNSHIFT_TIME      = 8'h13;
    localparam logic [7:0] ADDR_REST_ONE_FRAME_PERIOD   = 8'h14;
    localparam logic [7:0] ADDR_REST_ONE_DOWNSHIFT_TIME = 8'h15;
    localparam logic [7:0] ADDR_REST_TWO_FRAME_PERIOD   = 8'h16;
    localparam logic [7:0] ADDR_REST_TWO_DOWNSHIFT_TIME = 8'h17;
    localparam logic [7:0] ADDR_REST_THREE_FRAME_PERIOD = 8'h18;
    localparam logic [7:0] ADDR_LAMP_DRIVE_CONTROL      = 8'h1a;

    // reset values
    localparam logic [7:0] RST_RUN_DOWNSHIFT_TIME      = 8'h04;
    localparam logic [7:0] RST_REST_ONE_FRAME_PERIOD   = 8'h01;
    localparam logic [7:0] RST_REST_ONE_DOWNSHIFT_TIME = 8'h1f;
    localparam logic [7:0] RST_REST_TWO_FRAME_PERIOD   = 8'h09;
    localparam logic [7:0] RST_REST_TWO_DOWNSHIFT_TIME = 8'h2f;
    localparam logic [7:0] RST_REST_THREE_FRAME_PERIOD = 8'h31;
    localparam logic [3:0] RST_LAMP_DRIVE_CONTROL      = 4'h0;
    localparam logic [7:0] READ_UNMAPPED               = 8'h00;

    // field positions
    localparam int BTN_LEVEL_BIT  = 0;
    localparam int BTN_FALL_LSB   = 4;
    localparam int BTN_RISE_LSB   = 6;
    localparam int LAMP_FORCE_BIT = 3;
    localparam int LAMP_CODE_MSB  = 2;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_REST_ONE,
        MODE_REST_TWO,
        MODE_REST_THREE
    } pmd_mode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pmd_reg_req_t;

    typedef struct packed {
        logic [1:0] rise_count;
        logic [1:0] fall_count;
        logic       level;
    } pmd_button_t;

endpackage : pmd_pkg

/* File: hdl/pmd_power_mode.sv */
/*
 * Power-mode downshift block: register file, run/rest mode sequencer,
 * frame strobes and lamp control.
 * Assumes a register port already decoded from the serial front end,
 * inputs synchronous to mclk, and one clock enable that freezes state.
 */
`timescale 1ns/1ns
module pmd_power_mode #(
    parameter int RUN_FRAME_CYCLES = pmd_pkg::RUN_FRAME_CYCLES,
    parameter int HIB_TICK_CYCLES  = pmd_pkg::HIB_TICK_CYCLES
) (
    input  wire logic                  mclk,
    input  wire logic                  srst,
    input  wire logic                  ce,
    input  wire pmd_pkg::pmd_reg_req_t reg_req,
    input  wire logic                  button_level,
    input  wire logic                  motion_detect,
    output logic [7:0]                 reg_rdata,
    output pmd_pkg::pmd_mode_t         power_mode,
    output logic                       frame_capture,
    output logic [2:0]                 lamp_drive_code,
    output logic                       lamp_force_on,
    output logic                       lamp_on
);

    // target frame count for a downshift
    // 16 bits hold the largest target, 255 x 128 frames
    function automatic logic [15:0] shift_target(
        input logic [7:0] field,
        input logic [7:0] mult
    );
        logic [15:0] product;
        product = {8'h00, field} * {8'h00, mult};
        return product;
    endfunction : shift_target

    // registers
    logic [7:0] run_downshift_time;
    logic [7:0] rest_one_frame_period;
    logic [7:0] rest_one_downshift_time;
    logic [7:0] rest_two_frame_period;
    logic [7:0] rest_two_downshift_time;
    logic [7:0] rest_three_frame_period;
    logic [3:0] lamp_drive_control;

    // sequencer state
    logic [15:0] frame_count;
    logic [7:0]  rest_tick_count;

    pmd_pkg::pmd_button_t button_status;

    // decode
    wire hit_button;
    wire hit_run_shift;
    wire hit_one_period;
    wire hit_one_shift;
    wire hit_two_period;
    wire hit_two_shift;
    wire hit_three_period;
    wire hit_lamp;
    wire wr_en;

    assign wr_en            = reg_req.wr;
    assign hit_button       = reg_req.addr == pmd_pkg::ADDR_BUTTON_STATE_COUNTS;
    assign hit_run_shift    = reg_req.addr == pmd_pkg::ADDR_RUN_DOWNSHIFT_TIME;
    assign hit_one_period   = reg_req.addr == pmd_pkg::ADDR_REST_ONE_FRAME_PERIOD;
    assign hit_one_shift    = reg_req.addr == pmd_pkg::ADDR_REST_ONE_DOWNSHIFT_TIME;
    assign hit_two_period   = reg_req.addr == pmd_pkg::ADDR_REST_TWO_FRAME_PERIOD;
    assign hit_two_shift    = reg_req.addr == pmd_pkg::ADDR_REST_TWO_DOWNSHIFT_TIME;
    assign hit_three_period = reg_req.addr == pmd_pkg::ADDR_REST_THREE_FRAME_PERIOD;
    assign hit_lamp         = reg_req.addr == pmd_pkg::ADDR_LAMP_DRIVE_CONTROL;

    wire button_clear;
    assign button_clear = wr_en & hit_button;

    // read mux
    wire [7:0] button_read;
    wire [7:0] read_value;

    assign button_read = {button_status.rise_count,
                          button_status.fall_count,
                          3'h0,
                          button_status.level};

    // unmapped and reserved offsets read as zero
    assign read_value =
        hit_button       ? button_read :
        hit_run_shift    ? run_downshift_time :
        hit_one_period   ? rest_one_frame_period :
        hit_one_shift    ? rest_one_downshift_time :
        hit_two_period   ? rest_two_frame_period :
        hit_two_shift    ? rest_two_downshift_time :
        hit_three_period ? rest_three_frame_period :
        hit_lamp         ? {4'h0, lamp_drive_control} :
                           pmd_pkg::READ_UNMAPPED;

    // timing sources
    wire run_tick;
    wire hib_tick;
    wire run_restart;
    wire in_run;

    assign in_run = (power_mode == pmd_pkg::MODE_RUN);
    // held in restart outside run, so re-entry starts a full frame
    // motion realigns run frames
    assign run_restart = motion_detect | ~in_run;

    pmd_tick_gen #(
        .CYCLES (RUN_FRAME_CYCLES)
    ) u_run_tick (
        .mclk    (mclk),
        .srst    (srst),
        .ce      (ce),
        .restart (run_restart),
        .tick    (run_tick)
    );

    // free running: the first rest frame after a mode change may come early
    // free-running hibernate tick
    pmd_tick_gen #(
        .CYCLES (HIB_TICK_CYCLES)
    ) u_hib_tick (
        .mclk    (mclk),
        .srst    (srst),
        .ce      (ce),
        .restart (1'b0),
        .tick    (hib_tick)
    );

    pmd_button_track u_button (
        .mclk         (mclk),
        .srst         (srst),
        .ce           (ce),
        .button_level (button_level),
        .clear        (button_clear),
        .status       (button_status)
    );

    // per-mode selections
    logic [7:0]  period_sel;
    logic [15:0] target_sel;
    logic        can_shift;
    pmd_pkg::pmd_mode_t lower_mode;

    always_comb begin
        period_sel = 8'h00;
        target_sel = 16'h0000;
        can_shift  = 1'b0;
        lower_mode = power_mode;
        case (power_mode)
            pmd_pkg::MODE_RUN: begin
                target_sel = shift_target(run_downshift_time, pmd_pkg::RUN_SHIFT_MULT);
                can_shift  = 1'b1;
                lower_mode = pmd_pkg::MODE_REST_ONE;
            end
            pmd_pkg::MODE_REST_ONE: begin
                period_sel = rest_one_frame_period;
                target_sel = shift_target(rest_one_downshift_time,
                                          pmd_pkg::REST_ONE_SHIFT_MULT);
                can_shift  = 1'b1;
                lower_mode = pmd_pkg::MODE_REST_TWO;
            end
            pmd_pkg::MODE_REST_TWO: begin
                period_sel = rest_two_frame_period;
                target_sel = shift_target(rest_two_downshift_time,
                                          pmd_pkg::REST_TWO_SHIFT_MULT);
                can_shift  = 1'b1;
                lower_mode = pmd_pkg::MODE_REST_THREE;
            end
            pmd_pkg::MODE_REST_THREE: begin
                period_sel = rest_three_frame_period;
            end
            default: begin
                lower_mode = pmd_pkg::MODE_RUN;
            end
        endcase
    end

    // frame and downshift events
    wire        rest_frame_done;
    wire        frame_event;
    wire [15:0] frames_after;
    wire        downshift_due;

    // rest frame = (period+1) hibernate ticks
    assign rest_frame_done = ~in_run & hib_tick & (rest_tick_count == period_sel);
    assign frame_event     = in_run ? run_tick : rest_frame_done;
    assign frames_after    = frame_count + 16'h0001;
    // field of zero shifts after the first frame
    assign downshift_due   = can_shift & frame_event & (frames_after >= target_sel);

    // next state
    pmd_pkg::pmd_mode_t next_power_mode;
    logic [15:0]        next_frame_count;
    logic [7:0]         next_rest_tick_count;

    always_comb begin
        next_power_mode      = power_mode;
        next_frame_count     = frame_count;
        next_rest_tick_count = rest_tick_count;
        if (motion_detect) begin
            // motion wins over a same-cycle downshift
            // back to run, timer restarted
            next_power_mode      = pmd_pkg::MODE_RUN;
            next_frame_count     = 16'h0000;
            next_rest_tick_count = 8'h00;
        end else if (downshift_due) begin
            next_power_mode      = lower_mode;
            next_frame_count     = 16'h0000;
            next_rest_tick_count = 8'h00;
        end else begin
            // rest three never shifts, so its count is held to avoid wrap
            if (frame_event & can_shift) begin
                next_frame_count = frames_after;
            end
            if (rest_frame_done) begin
                next_rest_tick_count = 8'h00;
            end else if (~in_run & hib_tick) begin
                next_rest_tick_count = rest_tick_count + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            power_mode      <= pmd_pkg::MODE_RUN;
            frame_count     <= 16'h0000;
            rest_tick_count <= 8'h00;
            frame_capture   <= 1'b0;
            lamp_on         <= 1'b0;
        end else if (ce) begin
            power_mode      <= next_power_mode;
            frame_count     <= next_frame_count;
            rest_tick_count <= next_rest_tick_count;
            frame_capture   <= frame_event;
            // unforced lamp is lit only in the frame cycle
            // force keeps lamp lit
            lamp_on         <= lamp_drive_control[pmd_pkg::LAMP_FORCE_BIT] | frame_event;
        end
    end

    // register writes
    always_ff @(posedge mclk) begin
        if (srst) begin
            run_downshift_time      <= pmd_pkg::RST_RUN_DOWNSHIFT_TIME;
            rest_one_frame_period   <= pmd_pkg::RST_REST_ONE_FRAME_PERIOD;
            rest_one_downshift_time <= pmd_pkg::RST_REST_ONE_DOWNSHIFT_TIME;
            rest_two_frame_period   <= pmd_pkg::RST_REST_TWO_FRAME_PERIOD;
            rest_two_downshift_time <= pmd_pkg::RST_REST_TWO_DOWNSHIFT_TIME;
            rest_three_frame_period <= pmd_pkg::RST_REST_THREE_FRAME_PERIOD;
            lamp_drive_control      <= pmd_pkg::RST_LAMP_DRIVE_CONTROL;
        end else if (ce & wr_en) begin
            if (hit_run_shift) begin
                run_downshift_time <= reg_req.wdata;
            end
            if (hit_one_period) begin
                rest_one_frame_period <= reg_req.wdata;
            end
            if (hit_one_shift) begin
                rest_one_downshift_time <= reg_req.wdata;
            end
            if (hit_two_period) begin
                rest_two_frame_period <= reg_req.wdata;
            end
            if (hit_two_shift) begin
                rest_two_downshift_time <= reg_req.wdata;
            end
            if (hit_three_period) begin
                rest_three_frame_period <= reg_req.wdata;
            end
            if (hit_lamp) begin
                lamp_drive_control <= reg_req.wdata[3:0];
            end
        end
    end

    // read data and lamp outputs
    // rdata holds between reads, so a slow host may fetch it late
    always_ff @(posedge mclk) begin
        if (srst) begin
            reg_rdata       <= 8'h00;
            lamp_drive_code <= 3'h0;
            lamp_force_on   <= 1'b0;
        end else if (ce) begin
            if (reg_req.rd) begin
                reg_rdata <= read_value;
            end
            lamp_drive_code <= lamp_drive_control[pmd_pkg::LAMP_CODE_MSB:0];
            lamp_force_on   <= lamp_drive_control[pmd_pkg::LAMP_FORCE_BIT];
        end
    end

endmodule : pmd_power_mode

/* File: hdl/pmd_tick_gen.sv */
/*
 * Cycle divider: one-cycle tick every CYCLES enabled clocks, with a
 * restart that realigns the period.
 * Assumes CYCLES fits the counter width and is at least one.
 */
`timescale 1ns/1ns
module pmd_tick_gen #(
    parameter int CYCLES = 1000
) (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic restart,
    output logic      tick
);

    logic [pmd_pkg::TICK_CNT_W-1:0] count;
    wire                            at_end;

    assign at_end = (count == pmd_pkg::TICK_CNT_W'(CYCLES - 1));

    always_ff @(posedge mclk) begin
        if (srst) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (ce) begin
            tick  <= at_end & ~restart;
            count <= (restart | at_end) ? '0 : count + 1'b1;
        end
    end

endmodule : pmd_tick_gen

/* File: tb/pmd_host_model.sv */
/*
 * Host side model: one register request per call on the decoded port.
 * Assumes the block takes requests on the rising mclk edge.
 */
`timescale 1ns/1ns
module pmd_host_model (
    input  wire logic             mclk,
    input  wire logic [7:0]       reg_rdata,
    output pmd_pkg::pmd_reg_req_t reg_req
);
    initial reg_req = '0;

    // released address and data lines show inverted values, never the last ones
    task automatic access(
        input  logic       wr,
        input  logic [7:0] addr,
        input  logic [7:0] wdata,
        input  int         gap,
        output logic [7:0] rdata
    );
        repeat (gap + 1) @(negedge mclk);
        reg_req = '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
        @(negedge mclk);
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
        rdata = reg_rdata;
    endtask : access
endmodule : pmd_host_model

/* File: tb/pmd_power_mode_chk.sv */
/*
 * Checker for the power-mode block, bound to its top module ports.
 * Assumes ce high for most of the run and frame periods of 2+ cycles.
 */
`timescale 1ns/1ns
module pmd_power_mode_chk #(
    parameter int RUN_FRAME_CYCLES = 20,
    parameter int HIB_TICK_CYCLES  = 10
) (
    input wire logic                  mclk,
    input wire logic                  srst,
    input wire logic                  ce,
    input wire pmd_pkg::pmd_reg_req_t reg_req,
    input wire logic                  button_level,
    input wire logic                  motion_detect,
    input wire logic [7:0]            reg_rdata,
    input wire pmd_pkg::pmd_mode_t    power_mode,
    input wire logic                  frame_capture,
    input wire logic [2:0]            lamp_drive_code,
    input wire logic                  lamp_force_on,
    input wire logic                  lamp_on
);
    wire sel_btn  = reg_req.addr == pmd_pkg::ADDR_BUTTON_STATE_COUNTS;
    wire sel_lamp = reg_req.addr == pmd_pkg::ADDR_LAMP_DRIVE_CONTROL;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_motion_run;
        ce && motion_detect |=> power_mode == pmd_pkg::MODE_RUN;
    endproperty
    a_motion_run: assert property (p_motion_run)
        else $error("motion did not return to run mode");
    property p_mode_order;
        $changed(power_mode) |->
            power_mode == pmd_pkg::MODE_RUN || power_mode == 2'($past(power_mode) + 2'd1);
    endproperty
    a_mode_order: assert property (p_mode_order)
        else $error("power mode skipped a step");
    property p_lamp_on;
        lamp_on == (lamp_force_on | frame_capture);
    endproperty
    a_lamp_on: assert property (p_lamp_on)
        else $error("lamp level wrong");
    property p_frame_pulse;
        ce && frame_capture |=> !frame_capture;
    endproperty
    a_frame_pulse: assert property (p_frame_pulse)
        else $error("frame pulse longer than one cycle");
    property p_level;
        ce && $past(ce) && reg_req.rd && sel_btn |=> reg_rdata[0] == $past(button_level, 2);
    endproperty
    a_level: assert property (p_level)
        else $error("button level bit wrong");
    property p_clear;
        ce && reg_req.wr && sel_btn && $stable(button_level) ##1 ce && $stable(button_level)
            ##1 ce && reg_req.rd && sel_btn && $stable(button_level) |=> reg_rdata[7:4] == 4'h0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("counts not cleared by write");
    property p_lamp_code;
        ce && reg_req.wr && sel_lamp ##1 ce && !(reg_req.wr && sel_lamp) |=>
            lamp_drive_code == $past(reg_req.wdata[2:0], 2) &&
            lamp_force_on == $past(reg_req.wdata[3], 2);
    endproperty
    a_lamp_code: assert property (p_lamp_code)
        else $error("lamp outputs do not follow register");
    property p_rest3_hold;
        ce && !motion_detect && power_mode == pmd_pkg::MODE_REST_THREE |=>
            power_mode == pmd_pkg::MODE_REST_THREE;
    endproperty
    a_rest3_hold: assert property (p_rest3_hold)
        else $error("left deepest rest mode without motion");

    c_rest3: cover property (power_mode == pmd_pkg::MODE_REST_THREE);
    c_rest_frame: cover property (frame_capture && power_mode == pmd_pkg::MODE_REST_ONE);
    c_clear: cover property (ce && reg_req.wr && sel_btn);
endmodule : pmd_power_mode_chk

bind pmd_power_mode pmd_power_mode_chk #(
    .RUN_FRAME_CYCLES(RUN_FRAME_CYCLES),
    .HIB_TICK_CYCLES (HIB_TICK_CYCLES)
) u_pmd_power_mode_chk (.mclk, .srst, .ce, .reg_req, .button_level, .motion_detect,
    .reg_rdata, .power_mode, .frame_capture, .lamp_drive_code, .lamp_force_on, .lamp_on);

/* File: tb/tb_top.sv */
/*
 * Self-checking bench for the power-mode block with short frame counts.
 * Assumes the host model drives the register port at falling edges.
 */
`timescale 1ns/1ns
module tb_top;
    localparam int RUNC = 20;
    localparam int HIBC = 10;
    logic                  mclk = 1'b0;
    logic                  srst = 1'b1;
    logic                  ce = 1'b1;
    logic                  button_level = 1'b0;
    logic                  motion_detect = 1'b0;
    pmd_pkg::pmd_reg_req_t reg_req;
    logic [7:0]            reg_rdata;
    pmd_pkg::pmd_mode_t    power_mode;
    logic                  frame_capture;
    logic [2:0]            lamp_drive_code;
    logic                  lamp_force_on;
    logic                  lamp_on;
    int                    failures = 0;
    int                    samples_checked = 0;
    int                    cycles = 0;
    int                    rise = 0;
    int                    fall = 0;
    int                    k;
    logic [7:0]            v;
    logic [7:0]            e;
    logic [7:0] addrs [9] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1a, 8'h19};
    logic [7:0] rstv  [9] = '{8'h00, 8'h04, 8'h01, 8'h1f, 8'h09, 8'h2f, 8'h31, 8'h00, 8'h00};

    pmd_power_mode #(.RUN_FRAME_CYCLES(RUNC), .HIB_TICK_CYCLES(HIBC)) u_pmd_power_mode (
        .mclk(mclk), .srst(srst), .ce(ce), .reg_req(reg_req), .button_level(button_level),
        .motion_detect(motion_detect), .reg_rdata(reg_rdata), .power_mode(power_mode),
        .frame_capture(frame_capture), .lamp_drive_code(lamp_drive_code),
        .lamp_force_on(lamp_force_on), .lamp_on(lamp_on));
    pmd_host_model u_pmd_host_model (.mclk(mclk), .reg_rdata(reg_rdata), .reg_req(reg_req));

    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run

    task automatic check(input bit ok, input string msg);
        samples_checked++;
        if (!ok) begin
            failures++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        u_pmd_host_model.access(1'b1, a, d, $urandom_range(2), r);
    endtask : wr_reg

    task automatic expect_reg(input logic [7:0] a, input logic [7:0] x);
        logic [7:0] r;
        u_pmd_host_model.access(1'b0, a, 8'h00, 0, r);
        check(r === x, "register read");
    endtask : expect_reg

    task automatic step_time(input int lo, input int hi);
        pmd_pkg::pmd_mode_t m;
        int n;
        m = power_mode;
        n = 0;
        while (power_mode === m && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        check(n >= lo && n <= hi, "downshift time");
    endtask : step_time

    task automatic frame_gap(input int x);
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (frame_capture !== 1'b1 && n < 500);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (frame_capture !== 1'b1 && n < 500);
        check(n == x, "frame spacing");
    endtask : frame_gap

    task automatic pulse_motion();
        @(negedge mclk);
        motion_detect = 1'b1;
        @(negedge mclk);
        motion_detect = 1'b0;
    endtask : pulse_motion

    // hang guard, well above the expected run length
    initial begin
        forever begin
            @(posedge mclk);
            cycles++;
            if (cycles == 12000) begin
                failures++;
                complete_run();
            end
        end
    end

    initial begin
        void'($urandom(89700));
        repeat (8) @(negedge mclk);
        srst = 1'b0;
        for (int i = 0; i < 9; i++) expect_reg(addrs[i], rstv[i]);
        $display("test reset values done");
        for (int i = 1; i < 9; i++) begin
            v = 8'($urandom);
            wr_reg(addrs[i], v);
            e = (i == 8) ? 8'h00 : (i == 7) ? {4'h0, v[3:0]} : v;
            expect_reg(addrs[i], e);
            if (i == 7) check(lamp_drive_code === v[2:0] && lamp_force_on === v[3] &&
                              (lamp_on === 1'b1 || !v[3]), "lamp");
        end
        $display("test register access done");
        for (int i = 0; i < 40; i++) begin
            @(negedge mclk);
            v[0] = 1'($urandom);
            if (v[0] !== button_level) begin
                if (v[0]) rise++;
                else fall++;
            end
            button_level = v[0];
        end
        expect_reg(8'h12, {2'(rise), 2'(fall), 3'b000, button_level});
        wr_reg(8'h12, 8'($urandom));
        expect_reg(8'h12, {7'h00, button_level});
        @(negedge mclk);
        button_level = ~button_level;
        e = button_level ? 8'h41 : 8'h10;
        expect_reg(8'h12, e);
        $display("test button status done");
        wr_reg(8'h13, 8'h01);
        wr_reg(8'h14, 8'h00);
        wr_reg(8'h15, 8'h01);
        wr_reg(8'h16, 8'h00);
        wr_reg(8'h17, 8'h01);
        wr_reg(8'h18, 8'h02);
        wr_reg(8'h1a, 8'h00);
        pulse_motion();
        frame_gap(RUNC);
        pulse_motion();
        check(power_mode === pmd_pkg::MODE_RUN, "run after motion");
        step_time(8 * RUNC - 2, 8 * RUNC + 2);
        check(power_mode === pmd_pkg::MODE_REST_ONE, "rest one");
        step_time(16 * HIBC - HIBC - 1, 16 * HIBC + 2);
        check(power_mode === pmd_pkg::MODE_REST_TWO, "rest two");
        step_time(128 * HIBC - HIBC - 1, 128 * HIBC + 2);
        check(power_mode === pmd_pkg::MODE_REST_THREE, "rest three");
        frame_gap(3 * HIBC);
        check(lamp_on === 1'b1, "lamp lit on frame");
        $display("test downshift done");
        @(negedge mclk);
        ce = 1'b0;
        k = 0;
        repeat (4 * HIBC) begin
            @(negedge mclk);
            if (frame_capture === 1'b1 || power_mode !== pmd_pkg::MODE_REST_THREE ||
                lamp_on !== 1'b0) k++;
        end
        check(k == 0, "state moved while disabled");
        ce = 1'b1;
        pulse_motion();
        check(power_mode === pmd_pkg::MODE_RUN, "motion wakes rest three");
        $display("test freeze and wake done");
        complete_run();
    end
endmodule : tb_top
